// ===== design/config_loader_defs.svh
// constants for the configuration word loader
`ifndef CONFIG_LOADER_DEFS_SVH
`define CONFIG_LOADER_DEFS_SVH

// address map
`define CFG_SPACE_LO      24'h800000
`define CFG_REG_BASE      24'hF80000
`define CW1_ADDR_SMALL    24'h0157FE
`define CW1_ADDR_MID      24'h020BFE
`define CW1_ADDR_LARGE    24'h02ABFE
`define CW_STRIDE         24'h000002
`define FLASH_PAGE_MASK   24'hFFF800

// bit fields of config word one
`define CW1_SCAN_EN_BIT   14
`define CW1_CODE_PROT_BIT 13
`define CW1_WR_PROT_BIT   12
`define CW1_DEBUG_BIT     11
`define CW1_EMU_HI        9
`define CW1_EMU_LO        8
`define CW1_WDT_EN_BIT    7
`define CW1_WIN_DIS_BIT   6
`define CW1_PRESCALE_BIT  4
`define CW1_POST_HI       3
`define CW1_POST_LO       0

// read-back forcing, reset and prescale values
`define CW1_ONES_MASK     24'hFF0020
`define CW_UPPER_ONES     24'hFF0000
`define CW_RESET_VALUE    24'h000000
`define PRESCALE_FAST     8'h20
`define PRESCALE_SLOW     8'h80

`endif

// ===== design/config_loader_pkg.sv
// types shared by the configuration word loader
`default_nettype none
package config_loader_pkg;
   typedef logic [23:0] word24_t;
   typedef enum logic [2:0] {
      LD_IDLE = 3'b000,
      LD_W1   = 3'b001,
      LD_W2   = 3'b010,
      LD_W3   = 3'b011,
      LD_DONE = 3'b100
   } load_state_t;
endpackage
`default_nettype wire

// ===== design/cw1_decode.sv
// decoder for the fields of configuration word one
`timescale 1ns/1ps
`default_nettype none
`include "config_loader_defs.svh"
module cw1_decode
   import config_loader_pkg::*;
(
   // packed word
   input  wire word24_t    cw1,
   // decoded settings
   output logic            scan_port_enable,
   output logic            general_code_protect,
   output logic            general_flash_write_protect,
   output logic            debug_mode,
   output logic [2:0]      emulator_pin_placement,
   output logic            emu_cfg_reserved,
   output logic            watchdog_enable_cfg,
   output logic            watchdog_windowed,
   output logic            watchdog_cfg_invalid,
   output logic [7:0]      watchdog_prescale_select,
   output logic [3:0]      watchdog_postscale_select
);
   logic [1:0] emu_code;

   assign emu_code = cw1[`CW1_EMU_HI:`CW1_EMU_LO];
   assign scan_port_enable = cw1[`CW1_SCAN_EN_BIT];
   assign general_code_protect = ~cw1[`CW1_CODE_PROT_BIT];
   assign general_flash_write_protect = ~cw1[`CW1_WR_PROT_BIT];
   assign debug_mode = ~cw1[`CW1_DEBUG_BIT];

   // one-hot: bit0 pair one, bit1 pair two, bit2 pair three
   always_comb begin
      unique case (emu_code)
         2'b11: emulator_pin_placement = 3'b001;
         2'b10: emulator_pin_placement = 3'b010;
         2'b01: emulator_pin_placement = 3'b100;
         2'b00: emulator_pin_placement = 3'b000;
      endcase
   end
   assign emu_cfg_reserved = (emu_code == 2'b00);

   assign watchdog_enable_cfg = cw1[`CW1_WDT_EN_BIT];
   assign watchdog_windowed = ~cw1[`CW1_WIN_DIS_BIT];
   // windowed mode without the watchdog on is a bad image
   assign watchdog_cfg_invalid = ~cw1[`CW1_WIN_DIS_BIT]
                               & ~cw1[`CW1_WDT_EN_BIT];
   assign watchdog_prescale_select = cw1[`CW1_PRESCALE_BIT] ?
      `PRESCALE_SLOW : `PRESCALE_FAST;
   // ratio is 2 to the power of this field
   assign watchdog_postscale_select =
      cw1[`CW1_POST_HI:`CW1_POST_LO];
endmodule // cw1_decode
`default_nettype wire

// ===== design/config_word_loader.sv
// configuration word loader: reset-time unpack, table access, decode
`timescale 1ns/1ps
`default_nettype none
`include "config_loader_defs.svh"
module config_word_loader
   import config_loader_pkg::*;
#(
   parameter int SIZE_SEL = 2
)(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       dev_reset_req,
   // flash read port
   output logic            flash_rd_req,
   output word24_t         flash_rd_addr,
   input  wire logic       flash_rd_valid,
   input  wire word24_t    flash_rd_data,
   // flash write and erase port
   output logic            flash_wr_req,
   output word24_t         flash_wr_addr,
   output word24_t         flash_wr_data,
   output logic            flash_erase_req,
   output word24_t         flash_erase_addr,
   // table access port
   input  wire logic       tbl_req,
   input  wire logic       tbl_wr,
   input  wire word24_t    tbl_addr,
   input  wire word24_t    tbl_wdata,
   output logic            tbl_ack,
   output logic            tbl_err,
   output word24_t         tbl_rdata,
   // erase request from the cpu
   input  wire logic       erase_req,
   input  wire word24_t    erase_addr,
   // instruction fetch check
   input  wire word24_t    fetch_addr,
   output logic            fetch_block,
   // programming path pin
   input  wire logic       prog_via_scan_pin,
   // status
   output logic            cfg_loaded,
   output logic            cpu_hold,
   output logic            last_page_erased,
   // decoded settings
   output logic            scan_port_enable,
   output logic            general_code_protect,
   output logic            general_flash_write_protect,
   output logic            debug_mode,
   output logic [2:0]      emulator_pin_placement,
   output logic            emu_cfg_reserved,
   output logic            watchdog_enable_cfg,
   output logic            watchdog_windowed,
   output logic            watchdog_cfg_invalid,
   output logic [7:0]      watchdog_prescale_select,
   output logic [3:0]      watchdog_postscale_select
);
   ////////////////////////////////////////////////////////////////////
   // declarations
   ////////////////////////////////////////////////////////////////////
   localparam word24_t CW1_ADDR = (SIZE_SEL == 0) ? `CW1_ADDR_SMALL :
                                  (SIZE_SEL == 1) ? `CW1_ADDR_MID :
                                                    `CW1_ADDR_LARGE;
   localparam word24_t CW2_ADDR = CW1_ADDR - `CW_STRIDE;
   localparam word24_t CW3_ADDR = CW2_ADDR - `CW_STRIDE;
   localparam word24_t LAST_PAGE = CW3_ADDR & `FLASH_PAGE_MASK;

   load_state_t state_q;
   word24_t     cw_q [3];
   logic        scan_meta_q;
   logic        scan_s_q;
   logic        tbl_ack_q;
   logic        tbl_err_q;
   word24_t     tbl_rdata_q;
   logic        wr_req_q;
   word24_t     wr_addr_q;
   word24_t     wr_data_q;
   logic        erase_q;
   word24_t     erase_addr_q;
   logic        erased_q;
   logic        in_cfg;
   logic [23:0] cfg_off;
   logic        hit_cw;
   word24_t     wr_data_d;
   word24_t     rd_word;
   logic [1:0]  rd_idx;

   ////////////////////////////////////////////////////////////////////
   // pin synchroniser
   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scan_meta_q <= 1'b0;
         scan_s_q    <= 1'b0;
      end else begin
         scan_meta_q <= prog_via_scan_pin;
         scan_s_q    <= scan_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // load sequencer
   ////////////////////////////////////////////////////////////////////
   // any reset restarts the walk; after dev_reset_req stale settings last until the words reload
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= LD_IDLE;
      end else if (dev_reset_req) begin
         state_q <= LD_IDLE;
      end else begin
         unique case (state_q)
            LD_IDLE: state_q <= LD_W1;
            LD_W1:   if (flash_rd_valid) state_q <= LD_W2;
            LD_W2:   if (flash_rd_valid) state_q <= LD_W3;
            LD_W3:   if (flash_rd_valid) state_q <= LD_DONE;
            LD_DONE: state_q <= LD_DONE;
            default: state_q <= LD_IDLE;
         endcase
      end
   end

   assign flash_rd_req = (state_q == LD_W1) || (state_q == LD_W2) ||
                         (state_q == LD_W3);
   always_comb begin
      unique case (state_q)
         LD_W2:   flash_rd_addr = CW2_ADDR;
         LD_W3:   flash_rd_addr = CW3_ADDR;
         default: flash_rd_addr = CW1_ADDR;
      endcase
   end

   // volatile copies, cleared (fully protected) by rst until refilled; dev_reset_req keeps the old words
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cw_q[0] <= `CW_RESET_VALUE;
         cw_q[1] <= `CW_RESET_VALUE;
         cw_q[2] <= `CW_RESET_VALUE;
      end else if (flash_rd_valid) begin
         // bits kept as stored: programmed 0, blank 1
         if (state_q == LD_W1) cw_q[0] <= flash_rd_data;
         if (state_q == LD_W2) cw_q[1] <= flash_rd_data;
         if (state_q == LD_W3) cw_q[2] <= flash_rd_data;
      end
   end

   assign cfg_loaded = (state_q == LD_DONE);
   assign cpu_hold   = ~cfg_loaded;

   ////////////////////////////////////////////////////////////////////
   // table access
   ////////////////////////////////////////////////////////////////////
   assign in_cfg  = tbl_addr >= `CFG_SPACE_LO;
   assign cfg_off = tbl_addr - `CFG_REG_BASE;
   assign rd_idx  = cfg_off[2:1];
   assign hit_cw  = (tbl_addr == CW1_ADDR) || (tbl_addr == CW2_ADDR) ||
                    (tbl_addr == CW3_ADDR);
   assign fetch_block = fetch_addr >= `CFG_SPACE_LO;

   always_comb begin
      unique case (rd_idx)
         2'b00:   rd_word = cw_q[0] | `CW1_ONES_MASK;
         2'b01:   rd_word = cw_q[1] | `CW_UPPER_ONES;
         2'b10:   rd_word = cw_q[2] | `CW_UPPER_ONES;
         default: rd_word = 24'h000000;
      endcase
   end

   always_comb begin
      wr_data_d = tbl_wdata;
      if (hit_cw) begin
         wr_data_d[23:16] = 8'hFF;
      end
      // scan enable keeps its loaded value when written over the scan programming path
      if (tbl_addr == CW1_ADDR && scan_s_q) begin
         wr_data_d[`CW1_SCAN_EN_BIT] = cw_q[0][`CW1_SCAN_EN_BIT];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tbl_ack_q   <= 1'b0;
         tbl_err_q   <= 1'b0;
         tbl_rdata_q <= 24'h000000;
      end else begin
         tbl_ack_q <= tbl_req;
         tbl_err_q <= 1'b0;
         if (tbl_req && !tbl_wr) begin
            if (in_cfg && (tbl_addr & 24'hFFFFC0) == `CFG_REG_BASE
                && rd_idx != 2'b11) begin
               tbl_rdata_q <= rd_word;
            end else begin
               tbl_rdata_q <= 24'h000000;
               tbl_err_q   <= 1'b1;
            end
         end else if (tbl_req && tbl_wr) begin
            // loaded registers are not software writable
            tbl_err_q <= in_cfg || general_flash_write_protect;
         end
      end
   end
   assign tbl_ack   = tbl_ack_q;
   assign tbl_err   = tbl_err_q;
   assign tbl_rdata = tbl_rdata_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_req_q  <= 1'b0;
         wr_addr_q <= 24'h000000;
         wr_data_q <= 24'h000000;
      end else begin
         wr_req_q <= tbl_req && tbl_wr && !in_cfg
                     && !general_flash_write_protect;
         if (tbl_req && tbl_wr) begin
            wr_addr_q <= tbl_addr;
            wr_data_q <= wr_data_d;
         end
      end
   end
   assign flash_wr_req  = wr_req_q;
   assign flash_wr_addr = wr_addr_q;
   assign flash_wr_data = wr_data_q;

   ////////////////////////////////////////////////////////////////////
   // page erase
   ////////////////////////////////////////////////////////////////////
   // the flag survives until the next reload replaces the words
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         erase_q      <= 1'b0;
         erase_addr_q <= 24'h000000;
         erased_q     <= 1'b0;
      end else begin
         erase_q <= erase_req && !general_flash_write_protect;
         if (erase_req) erase_addr_q <= erase_addr;
         if (erase_req && !general_flash_write_protect
             && (erase_addr & `FLASH_PAGE_MASK) == LAST_PAGE) begin
            erased_q <= 1'b1;
         end else if (state_q == LD_W1 && flash_rd_valid) begin
            erased_q <= 1'b0;
         end
      end
   end
   assign flash_erase_req  = erase_q;
   assign flash_erase_addr = erase_addr_q;
   assign last_page_erased = erased_q;

   ////////////////////////////////////////////////////////////////////
   // decode
   ////////////////////////////////////////////////////////////////////
   cw1_decode u_decode (
      .cw1                         (cw_q[0]),
      .scan_port_enable            (scan_port_enable),
      .general_code_protect        (general_code_protect),
      .general_flash_write_protect (general_flash_write_protect),
      .debug_mode                  (debug_mode),
      .emulator_pin_placement      (emulator_pin_placement),
      .emu_cfg_reserved            (emu_cfg_reserved),
      .watchdog_enable_cfg         (watchdog_enable_cfg),
      .watchdog_windowed           (watchdog_windowed),
      .watchdog_cfg_invalid        (watchdog_cfg_invalid),
      .watchdog_prescale_select    (watchdog_prescale_select),
      .watchdog_postscale_select   (watchdog_postscale_select)
   );

   ////////////////////////////////////////////////////////////////////
   // assertions
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_hold_until_load: assert property (
      !cfg_loaded |-> cpu_hold)
      else $error("cpu released before load");
   a_reload_on_reset: assert property (
      dev_reset_req |=> !cfg_loaded ##1 (state_q == LD_W1))
      else $error("reset did not restart load");
   a_first_word_addr: assert property (
      (state_q == LD_W1) |-> flash_rd_addr == CW1_ADDR
      && flash_rd_req)
      else $error("first word address wrong");
   a_fetch_cfg_blocked: assert property (
      (fetch_addr >= `CFG_SPACE_LO) |-> fetch_block)
      else $error("fetch into config space allowed");
   a_cfg_write_ignored: assert property (
      (tbl_req && tbl_wr && tbl_addr >= `CFG_SPACE_LO)
      |=> tbl_ack && tbl_err && !flash_wr_req)
      else $error("config space write not refused");
   a_unimpl_read_ones: assert property (
      (tbl_req && !tbl_wr && tbl_addr == `CFG_REG_BASE)
      |=> tbl_rdata[23:16] == 8'hFF && tbl_rdata[5]
      && !tbl_err)
      else $error("unimplemented bits not read as one");
   a_write_protect: assert property (
      flash_wr_req |-> !$past(general_flash_write_protect))
      else $error("write passed while protected");
   a_upper_byte_ones: assert property (
      (flash_wr_req && (flash_wr_addr == CW1_ADDR
      || flash_wr_addr == CW3_ADDR)) |-> flash_wr_data[23:16] == 8'hFF)
      else $error("config word upper byte not ones");
   a_scan_bit_kept: assert property (
      (tbl_req && tbl_wr && tbl_addr == CW1_ADDR && scan_s_q
      && !general_flash_write_protect)
      |=> flash_wr_data[14] == $past(cw_q[0][14]))
      else $error("scan enable changed over scan port");
   a_erase_last_page: assert property (
      (erase_req && !general_flash_write_protect
      && (erase_addr & `FLASH_PAGE_MASK) == LAST_PAGE)
      |=> last_page_erased && flash_erase_req)
      else $error("last page erase not flagged");
   a_prescale_ratio: assert property (
      cfg_loaded |-> watchdog_prescale_select ==
      (cw_q[0][4] ? 8'h80 : 8'h20))
      else $error("prescale ratio wrong");

   c_load_done: cover property (state_q == LD_W3 ##1 cfg_loaded);
   c_cfg_read: cover property (tbl_req && !tbl_wr && in_cfg ##1 tbl_ack);
   c_flash_write: cover property (flash_wr_req);
   c_scan_masked: cover property (tbl_req && tbl_wr && scan_s_q);
endmodule // config_word_loader
`default_nettype wire

// ===== design/README_unused.sv
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== testbench/flash_model.sv
// behavioural program flash holding the configuration words
`timescale 1ns/1ps
`default_nettype none
`include "config_loader_defs.svh"
module flash_model
   import config_loader_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // read port
   input  wire logic       flash_rd_req,
   input  wire word24_t    flash_rd_addr,
   output logic            flash_rd_valid,
   output word24_t         flash_rd_data,
   // write and erase port
   input  wire logic       flash_wr_req,
   input  wire word24_t    flash_wr_addr,
   input  wire word24_t    flash_wr_data,
   input  wire logic       flash_erase_req,
   input  wire word24_t    flash_erase_addr,
   // answer latency in cycles
   input  wire logic [3:0] answer_delay
);
   word24_t    mem [word24_t];
   logic [3:0] wait_q;

   // blank cells read as ones
   function automatic word24_t peek(word24_t a);
      return mem.exists(a) ? mem[a] : 24'hFFFFFF;
   endfunction

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         flash_rd_valid <= 1'b0;
         flash_rd_data  <= 24'h000000;
         wait_q         <= 4'h0;
      end else if (flash_rd_valid || !flash_rd_req) begin
         // idle bus toggles so a stale word is never mistaken for data
         flash_rd_valid <= 1'b0;
         flash_rd_data  <= ~flash_rd_data;
         wait_q         <= 4'h0;
      end else if (wait_q >= answer_delay) begin
         flash_rd_valid <= 1'b1;
         flash_rd_data  <= peek(flash_rd_addr);
      end else begin
         wait_q        <= wait_q + 4'h1;
         flash_rd_data <= ~flash_rd_data;
      end
   end

   always @(posedge clk) begin
      if (flash_wr_req)
         mem[flash_wr_addr] = flash_wr_data;
      // page erase clears every word of the page already held in mem; unwritten words still read as ones
      if (flash_erase_req)
         foreach (mem[a])
            if ((a & `FLASH_PAGE_MASK) == (flash_erase_addr & `FLASH_PAGE_MASK))
               mem[a] = 24'h000000;
   end
endmodule // flash_model
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the configuration word loader
`timescale 1ns/1ps
`default_nettype none
`include "config_loader_defs.svh"
module tb
   import config_loader_pkg::*;
;
   localparam word24_t W1A = `CW1_ADDR_LARGE;
   logic       clk, flash_rd_req, flash_rd_valid, flash_wr_req, tbl_ack;
   logic       flash_erase_req, tbl_err, fetch_block, cfg_loaded, cpu_hold;
   logic       last_page_erased, scan_port_enable, general_code_protect;
   logic       general_flash_write_protect, debug_mode, emu_cfg_reserved;
   logic       watchdog_enable_cfg, watchdog_windowed, watchdog_cfg_invalid;
   logic       rst = 1'b1, dev_reset_req = 1'b0, prog_via_scan_pin = 1'b0;
   logic       tbl_req = 1'b0, tbl_wr = 1'b0, erase_req = 1'b0;
   word24_t    tbl_addr = '0, tbl_wdata = '0, erase_addr = '0, fetch_addr = '0;
   word24_t    flash_rd_addr, flash_rd_data, flash_wr_addr, flash_wr_data;
   word24_t    flash_erase_addr, tbl_rdata, w1, w2, w3, seen_rd, seen_wd;
   logic [2:0] emulator_pin_placement;
   logic [7:0] watchdog_prescale_select;
   logic [3:0] watchdog_postscale_select;
   logic [3:0] answer_delay = 4'h0;
   logic [15:0] rnd = 16'h002F;
   logic       seen_err, seen_wr;
   int         miscompares = 0, comparisons = 0;
   word24_t    rd_log [$];

   config_word_loader DUT (
      .clk(clk), .rst(rst), .dev_reset_req(dev_reset_req),
      .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
      .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
      .flash_wr_req(flash_wr_req), .flash_wr_addr(flash_wr_addr),
      .flash_wr_data(flash_wr_data), .flash_erase_req(flash_erase_req),
      .flash_erase_addr(flash_erase_addr), .tbl_req(tbl_req),
      .tbl_wr(tbl_wr), .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata),
      .tbl_ack(tbl_ack), .tbl_err(tbl_err), .tbl_rdata(tbl_rdata),
      .erase_req(erase_req), .erase_addr(erase_addr),
      .fetch_addr(fetch_addr), .fetch_block(fetch_block),
      .prog_via_scan_pin(prog_via_scan_pin), .cfg_loaded(cfg_loaded),
      .cpu_hold(cpu_hold), .last_page_erased(last_page_erased),
      .scan_port_enable(scan_port_enable),
      .general_code_protect(general_code_protect),
      .general_flash_write_protect(general_flash_write_protect),
      .debug_mode(debug_mode),
      .emulator_pin_placement(emulator_pin_placement),
      .emu_cfg_reserved(emu_cfg_reserved),
      .watchdog_enable_cfg(watchdog_enable_cfg),
      .watchdog_windowed(watchdog_windowed),
      .watchdog_cfg_invalid(watchdog_cfg_invalid),
      .watchdog_prescale_select(watchdog_prescale_select),
      .watchdog_postscale_select(watchdog_postscale_select));

   flash_model far_flash (
      .clk(clk), .rst(rst), .flash_rd_req(flash_rd_req),
      .flash_rd_addr(flash_rd_addr), .flash_rd_valid(flash_rd_valid),
      .flash_rd_data(flash_rd_data), .flash_wr_req(flash_wr_req),
      .flash_wr_addr(flash_wr_addr), .flash_wr_data(flash_wr_data),
      .flash_erase_req(flash_erase_req),
      .flash_erase_addr(flash_erase_addr), .answer_delay(answer_delay));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk)
      if (flash_rd_req && flash_rd_valid)
         rd_log.push_back(flash_rd_addr);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      if (miscompares == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // every load must fetch the three top words, highest first
   task automatic wait_loaded();
      int n;
      n = 0;
      while (cfg_loaded !== 1'b1) begin
         chk("cpu_hold", 1, cpu_hold);
         @(negedge clk);
         n++;
         if (n > 200) begin
            miscompares++;
            tally_and_finish();
         end
      end
      chk("cpu_hold", 0, cpu_hold);
      chk("reads", 3, rd_log.size());
      for (int i = 0; i < rd_log.size(); i++)
         chk("rd_addr", W1A - 24'(2 * i), rd_log[i]);
      rd_log.delete();
   endtask

   task automatic restart();
      dev_reset_req = 1'b1;
      @(negedge clk);
      dev_reset_req = 1'b0;
      wait_loaded();
   endtask

   task automatic reload(word24_t a, word24_t b, word24_t c, logic [3:0] d);
      far_flash.mem[W1A] = a;
      far_flash.mem[W1A - 24'h2] = b;
      far_flash.mem[W1A - 24'h4] = c;
      answer_delay = d;
      restart();
   endtask

   task automatic tbl_op(logic wr, word24_t a, word24_t d);
      tbl_req = 1'b1;
      tbl_wr = wr;
      tbl_addr = a;
      tbl_wdata = d;
      @(negedge clk);
      tbl_req = 1'b0;
      chk("tbl_ack", 1, tbl_ack);
      seen_err = tbl_err;
      seen_rd = tbl_rdata;
      seen_wr = flash_wr_req;
      seen_wd = flash_wr_data;
      // a free cycle so the strobe is never set twice in one step
      @(negedge clk);
      chk("tbl_ack_end", 0, tbl_ack);
   endtask

   task automatic chk_decode(word24_t w);
      logic [2:0] pin;
      pin = (w[9:8] == 2'b11) ? 3'b001 : (w[9:8] == 2'b10) ? 3'b010 :
            (w[9:8] == 2'b01) ? 3'b100 : 3'b000;
      chk("scan_en", w[14], scan_port_enable);
      chk("code_prot", !w[13], general_code_protect);
      chk("wr_prot", !w[12], general_flash_write_protect);
      chk("debug", !w[11], debug_mode);
      chk("emu_pins", pin, emulator_pin_placement);
      chk("emu_rsvd", w[9:8] == 2'b00, emu_cfg_reserved);
      chk("wdt_en", w[7], watchdog_enable_cfg);
      chk("wdt_win", !w[6], watchdog_windowed);
      chk("wdt_bad", !w[6] && !w[7], watchdog_cfg_invalid);
      chk("prescale", w[4] ? 8'h80 : 8'h20, watchdog_prescale_select);
      chk("postscale", w[3:0], watchdog_postscale_select);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(negedge clk);
      chk("rst_prot", 1, general_code_protect);
      chk("rst_hold", 1, cpu_hold);
      rst = 1'b0;
      wait_loaded();
      chk_decode(24'hFFFFFF);
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         w1 = {8'h00, rnd};
         w1[9:8] = i[1:0];
         if (i > 3)
            w1[3:0] = {4{i[0]}};
         rnd = lfsr(rnd);
         w2 = {rnd, 8'h00};
         rnd = lfsr(rnd);
         w3 = {rnd[7:0], rnd};
         reload(w1, w2, w3, i[3:0]);
         chk_decode(w1);
         tbl_op(1'b0, `CFG_REG_BASE, 24'h0);
         chk("cw1_rd", {8'hFF, w1[15:6], 1'b1, w1[4:0]}, seen_rd);
         chk("cw1_err", 0, seen_err);
         tbl_op(1'b0, `CFG_REG_BASE + 24'h2, 24'h0);
         chk("cw2_rd", {8'hFF, w2[15:0]}, seen_rd);
         tbl_op(1'b0, `CFG_REG_BASE + 24'h4, 24'h0);
         chk("cw3_rd", {8'hFF, w3[15:0]}, seen_rd);
      end
      tbl_op(1'b0, `CFG_REG_BASE + 24'h6, 24'h0);
      chk("bad_rd_err", 1, seen_err);
      chk("bad_rd_data", 0, seen_rd);
      fetch_addr = `CFG_SPACE_LO - 24'h2;
      #1 chk("fetch_user", 0, fetch_block);
      @(negedge clk);
      fetch_addr = `CFG_REG_BASE;
      #1 chk("fetch_cfg", 1, fetch_block);
      @(negedge clk);
      // loaded word keeps scan enable set, writes allowed
      reload(24'hFF5FFF, 24'hFFFFFF, 24'hFFFFFF, 4'h2);
      tbl_op(1'b1, W1A, 24'h001234);
      chk("wr_pulse", 1, seen_wr);
      chk("wr_data", 24'hFF1234, seen_wd);
      chk("wr_addr", W1A, flash_wr_addr);
      prog_via_scan_pin = 1'b1;
      repeat (3) @(negedge clk);
      tbl_op(1'b1, W1A, 24'h001234);
      chk("wr_scan", 24'hFF5234, seen_wd);
      prog_via_scan_pin = 1'b0;
      tbl_op(1'b1, `CFG_SPACE_LO, 24'h0);
      chk("cfg_wr_err", 1, seen_err);
      chk("cfg_wr_pass", 0, seen_wr);
      restart();
      chk_decode(24'hFF5234);
      erase_addr = W1A - 24'h4;
      erase_req = 1'b1;
      @(negedge clk);
      erase_req = 1'b0;
      chk("erase_pulse", 1, flash_erase_req);
      chk("erase_addr", W1A - 24'h4, flash_erase_addr);
      chk("page_flag", 1, last_page_erased);
      restart();
      chk_decode(24'h000000);
      chk("flag_clear", 0, last_page_erased);
      tbl_op(1'b1, W1A, 24'h00FFFF);
      chk("prot_wr_err", 1, seen_err);
      chk("prot_wr_pass", 0, seen_wr);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
